// [src/lpmrs_top.sv]
// low-power mode and reset sequencer with avalon-mm register slave
//
// Function
// - mode field 10 enters standby
// - stop bit stops high osc only if slow selected
// - enabled timers count, expiry wakes standby
// - standby halts cpu, low osc runs
// - standby wakes on any peripheral event
// - resume normal or slow by select bit
// - sleep instruction or mode 01 enters halt
// - halt entry clears pd, sets to, clears watchdog
// - halt stops cpu, peripherals, both oscillators
// - halt wakes on watchdog, port, external only
// - stop bit and halt in one write
// - halt wake waits 512 or 16 cycles
// - standby wake resumes without delay
// - wake vectors to interrupt if enabled
// - por, low voltage, pin, watchdog in run cause reset
// - reset loads defined values, keeps undefined ones
// - por/lvr set flags; pin sets from halt
// - watchdog, sleep, clear-watchdog flag values
// - power-up wait chosen by 3-bit field
// - settle wait 1 or 16 cycles
// - select bit is control bit 0
// - mode field is control bits 3:2
`timescale 1ns/100ps

module lpmrs_top
  import lpmrs_pkg::*;
#(
  parameter int P_PWRUP_T1_CYC = PWRUP_T1_CYC,
  parameter int P_PWRUP_T2_CYC = PWRUP_T2_CYC,
  parameter int P_PWRUP_T3_CYC = PWRUP_T3_CYC,
  parameter int P_PWRUP_T4_CYC = PWRUP_T4_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_por_detect,
  input wire logic i_low_voltage_reset,
  input wire logic i_reset_pin_n,
  input wire logic i_sleep_instr,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_wdt_timeout,
  input wire logic i_port_change,
  input wire logic i_ext_int,
  input wire logic i_lvd_event,
  input wire logic i_cmp_change,
  input wire logic i_adc_eoc,
  output logic o_sys_reset,
  output logic o_cpu_run,
  output logic o_high_osc_en,
  output logic o_low_osc_en,
  output logic o_sys_clk_high,
  output logic o_periph_en,
  output logic [NUM_TIMERS-1:0] o_timer_run,
  output logic o_wdt_clear,
  output logic o_int_vector
);

  // ***********************************************************
  // reset release and pin synchronisers
  // ***********************************************************
  logic rst_meta;
  logic rst_n;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 3'h3;
      pin_sync <= 3'h3;
    end
    else
    begin
      pin_meta <= {i_reset_pin_n, i_low_voltage_reset, i_por_detect};
      pin_sync <= pin_meta;
    end
  end

  // ***********************************************************
  // state and event decode
  // ***********************************************************
  lpmrs_state_t state;
  lpmrs_state_t next_state;
  logic [1:0] op_mode;
  logic clk_sel_high;
  logic high_osc_stop;
  logic power_down_flag;
  logic timeout_flag;
  logic [NUM_TIMERS-1:0] timer_en;
  logic [2:0] pwrup_sel;
  logic xtal_mode;
  logic gie;
  logic [TMR_W-1:0] timer_reload [NUM_TIMERS];
  logic [TMR_W-1:0] timer_count [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] timer_expired;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] pwrup_cyc;
  logic reset_hold;
  logic reset_evt;
  logic enter_halt;
  logic enter_standby;
  logic wake_halt;
  logic wake_standby;
  logic wr_acc;
  logic [ADDR_W-1:0] reload_addr [NUM_TIMERS];

  assign reset_hold = pin_sync[0] | pin_sync[1] | ~pin_sync[2];
  assign reset_evt = reset_hold | (i_wdt_timeout && state == ST_RUN);
  // halt entry by instruction or mode write
  assign enter_halt = state == ST_RUN &&
                      (i_sleep_instr || op_mode == MODE_HALT);
  assign enter_standby = state == ST_RUN && !i_sleep_instr &&
                         op_mode == MODE_STANDBY;
  assign wake_halt = state == ST_HALT &&
                     (i_wdt_timeout || i_port_change || i_ext_int);
  assign wake_standby = state == ST_STANDBY &&
                        (|timer_expired || i_wdt_timeout ||
                         i_port_change || i_ext_int || i_lvd_event ||
                         i_cmp_change || i_adc_eoc);
  assign wr_acc = i_write && !o_waitrequest;

  always_comb
  begin
    case (pwrup_sel)
      3'h0: pwrup_cyc = CNT_W'(PWRUP_T0_CYC);
      3'h1: pwrup_cyc = CNT_W'(P_PWRUP_T1_CYC);
      3'h2: pwrup_cyc = CNT_W'(P_PWRUP_T2_CYC);
      3'h3: pwrup_cyc = CNT_W'(P_PWRUP_T3_CYC);
      default: pwrup_cyc = CNT_W'(P_PWRUP_T4_CYC);
    endcase
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET:
        if (!reset_hold)
          next_state = ST_PWRUP;
      ST_PWRUP:
        if (cnt == '0)
          next_state = ST_SETTLE;
      ST_SETTLE:
        if (cnt == '0)
          next_state = ST_RUN;
      ST_RUN:
        if (enter_halt)
          next_state = ST_HALT;
        else if (enter_standby)
          next_state = ST_STANDBY;
      ST_STANDBY:
        if (wake_standby)
          next_state = ST_RUN;
      ST_HALT:
        if (wake_halt)
          next_state = ST_WAKE;
      ST_WAKE:
        if (cnt == '0)
          next_state = ST_RUN;
      default: next_state = ST_RESET;
    endcase
    if (reset_evt)
      next_state = ST_RESET;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_RESET;
    else
      state <= next_state;
  end

  // ***********************************************************
  // wait counter
  // ***********************************************************
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (state == ST_RESET)
      cnt <= pwrup_cyc - 1'b1;
    else if (state == ST_PWRUP && cnt == '0)
      cnt <= ((pwrup_sel == 3'h0) ? SETTLE_SHORT_CYC : SETTLE_LONG_CYC)
             - 1'b1;
    else if (wake_halt)
      cnt <= (xtal_mode ? WAKE_XTAL_CYC : WAKE_RC_CYC) - 1'b1;
    else if (cnt != '0)
      cnt <= cnt - 1'b1;
  end

  // ***********************************************************
  // software registers
  // ***********************************************************
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_mode <= MODE_RUN;
      clk_sel_high <= OSC_SEL_RST;
      high_osc_stop <= 1'b0;
      timer_en <= '0;
      gie <= 1'b0;
    end
    else if (reset_evt)
    begin
      op_mode <= MODE_RUN;
      clk_sel_high <= OSC_SEL_RST;
      high_osc_stop <= 1'b0;
      timer_en <= '0;
      gie <= 1'b0;
    end
    else
    begin
      if (wake_standby || (state == ST_WAKE && cnt == '0))
        op_mode <= MODE_RUN;
      // stop bit and mode in one write
      else if (wr_acc && i_address == ADDR_OSC_CTRL && i_byteenable[0])
      begin
        clk_sel_high <= i_writedata[OSC_SEL_BIT];
        high_osc_stop <= i_writedata[OSC_STOP_BIT];
        op_mode <= i_writedata[OSC_MODE_LO +: 2];
      end
      if (wr_acc && i_address == ADDR_TIMER_EN && i_byteenable[0])
        timer_en <= i_writedata[NUM_TIMERS-1:0];
      if (wr_acc && i_address == ADDR_CONFIG && i_byteenable[0])
        gie <= i_writedata[CFG_GIE_BIT];
    end
  end

  // power-up select and crystal mode fields keep their value across reset events
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwrup_sel <= CFG_PWRUP_RST;
      xtal_mode <= 1'b0;
    end
    else if (wr_acc && i_address == ADDR_CONFIG && i_byteenable[0])
    begin
      pwrup_sel <= i_writedata[2:0];
      xtal_mode <= i_writedata[CFG_XTAL_BIT];
    end
  end

  // ***********************************************************
  // timeout and power-down flags
  // ***********************************************************
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b1;
    end
    else if (pin_sync[0] || pin_sync[1])
    begin
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b1;
    end
    // reset pin only counts from halt
    else if (!pin_sync[2])
    begin
      if (state == ST_HALT)
      begin
        timeout_flag <= 1'b1;
        power_down_flag <= 1'b1;
      end
    end
    else if (i_wdt_timeout && state == ST_RUN)
    begin
      timeout_flag <= 1'b0;
      power_down_flag <= 1'b1;
    end
    else if (i_wdt_timeout && state == ST_HALT)
    begin
      timeout_flag <= 1'b0;
      power_down_flag <= 1'b0;
    end
    else if (enter_halt)
    begin
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b0;
    end
    else if (i_watchdog_clear_instr && state == ST_RUN)
    begin
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b1;
    end
  end

  // ***********************************************************
  // wake-up timers
  // ***********************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++)
    begin : g_tmr
      assign reload_addr[gi] = ADDR_RELOAD_BASE + ADDR_W'(gi * 4);

      always_ff @(posedge i_clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          timer_reload[gi] <= '0;
        else if (wr_acc && i_address == reload_addr[gi])
        begin
          if (i_byteenable[0])
            timer_reload[gi][7:0] <= i_writedata[7:0];
          if (i_byteenable[1])
            timer_reload[gi][9:8] <= i_writedata[9:8];
        end
      end

      // enabled timer counts in run and standby
      always_ff @(posedge i_clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          timer_count[gi] <= '0;
          timer_expired[gi] <= 1'b0;
        end
        else if (timer_en[gi] &&
                 (state == ST_RUN || state == ST_STANDBY))
        begin
          timer_expired[gi] <= timer_count[gi] == '0;
          if (timer_count[gi] == '0)
            timer_count[gi] <= timer_reload[gi];
          else
            timer_count[gi] <= timer_count[gi] - 1'b1;
        end
        else
          timer_expired[gi] <= 1'b0;
      end
    end
  endgenerate

  // ***********************************************************
  // registered outputs
  // ***********************************************************
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_sys_reset <= 1'b1;
      o_cpu_run <= 1'b0;
      o_high_osc_en <= 1'b1;
      o_low_osc_en <= 1'b1;
      o_sys_clk_high <= OSC_SEL_RST;
      o_periph_en <= 1'b0;
      o_timer_run <= '0;
      o_wdt_clear <= 1'b0;
      o_int_vector <= 1'b0;
    end
    else
    begin
      o_sys_reset <= state == ST_RESET || state == ST_PWRUP ||
                     state == ST_SETTLE;
      o_cpu_run <= state == ST_RUN;
      o_sys_clk_high <= clk_sel_high;
      o_low_osc_en <= state != ST_HALT;
      // stop honoured only in slow mode
      o_high_osc_en <= state != ST_HALT &&
                       !(high_osc_stop && !clk_sel_high);
      o_periph_en <= state == ST_RUN || state == ST_STANDBY;
      o_timer_run <= (state == ST_RUN || state == ST_STANDBY) ?
                     timer_en : '0;
      o_wdt_clear <= enter_halt ||
                     (i_watchdog_clear_instr && state == ST_RUN);
      o_int_vector <= gie && (wake_standby ||
                      (state == ST_WAKE && cnt == '0 && !reset_evt));
    end
  end

  // ***********************************************************
  // avalon-mm slave: one wait cycle per access
  // ***********************************************************
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_waitrequest <= 1'b1;
      o_readdata <= '0;
    end
    else if ((i_read || i_write) && o_waitrequest)
    begin
      o_waitrequest <= 1'b0;
      o_readdata <= '0;
      if (i_read)
      begin
        case (i_address)
          ADDR_OSC_CTRL:
            o_readdata[3:0] <= {op_mode, high_osc_stop, clk_sel_high};
          ADDR_STATUS:
            o_readdata[STAT_TO_BIT:STAT_PD_BIT] <=
              {timeout_flag, power_down_flag};
          ADDR_TIMER_EN: o_readdata[NUM_TIMERS-1:0] <= timer_en;
          ADDR_CONFIG: o_readdata[4:0] <= {gie, xtal_mode, pwrup_sel};
          ADDR_STATE: o_readdata[6:0] <= state;
          reload_addr[0]: o_readdata[TMR_W-1:0] <= timer_reload[0];
          reload_addr[1]: o_readdata[TMR_W-1:0] <= timer_reload[1];
          reload_addr[2]: o_readdata[TMR_W-1:0] <= timer_reload[2];
          reload_addr[3]: o_readdata[TMR_W-1:0] <= timer_reload[3];
          default: o_readdata <= '0;
        endcase
      end
    end
    else
      o_waitrequest <= 1'b1;
  end

endmodule : lpmrs_top

// [src/lpmrs_pkg.sv]
// constants for the low-power mode and reset sequencer
package lpmrs_pkg;

  // ***********************************************************
  // clock and timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int PWRUP_T0_US = 140;
  localparam int PWRUP_T1_US = 4500;
  localparam int PWRUP_T2_US = 18000;
  localparam int PWRUP_T3_US = 72000;
  localparam int PWRUP_T4_US = 288000;
  localparam int PWRUP_T0_CYC = (PWRUP_T0_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int PWRUP_T1_CYC = (PWRUP_T1_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int PWRUP_T2_CYC = (PWRUP_T2_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int PWRUP_T3_CYC = (PWRUP_T3_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int PWRUP_T4_CYC = (PWRUP_T4_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int CNT_W = 22;
  localparam logic [CNT_W-1:0] WAKE_XTAL_CYC = 22'h000200;
  localparam logic [CNT_W-1:0] WAKE_RC_CYC = 22'h000010;
  localparam logic [CNT_W-1:0] SETTLE_SHORT_CYC = 22'h000001;
  localparam logic [CNT_W-1:0] SETTLE_LONG_CYC = 22'h000010;

  // ***********************************************************
  // register map (byte addresses)
  // ***********************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TIMER_EN = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] ADDR_RELOAD_BASE = 8'h20;
  localparam int NUM_TIMERS = 4;
  localparam int TMR_W = 10;

  // oscillator_control_reg fields
  localparam int OSC_SEL_BIT = 0;
  localparam int OSC_STOP_BIT = 1;
  localparam int OSC_MODE_LO = 2;
  localparam logic OSC_SEL_RST = 1'h1;
  // status fields
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_TO_BIT = 4;
  // config fields
  localparam int CFG_XTAL_BIT = 3;
  localparam int CFG_GIE_BIT = 4;
  localparam logic [2:0] CFG_PWRUP_RST = 3'h0;

  // operating_mode_field encodings
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_HALT = 2'h1;
  localparam logic [1:0] MODE_STANDBY = 2'h2;

  typedef enum logic [6:0] {
    ST_RESET   = 7'h01,
    ST_PWRUP   = 7'h02,
    ST_SETTLE  = 7'h04,
    ST_RUN     = 7'h08,
    ST_STANDBY = 7'h10,
    ST_HALT    = 7'h20,
    ST_WAKE    = 7'h40
  } lpmrs_state_t;

endpackage : lpmrs_pkg

// [sim/lpmrs_assertions.sv]
// port-level checker of the mode and reset sequencer
`timescale 1ns/100ps

module lpmrs_checker
  import lpmrs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic o_waitrequest,
  input wire logic i_reset_pin_n,
  input wire logic i_wdt_timeout,
  input wire logic i_port_change,
  input wire logic i_ext_int,
  input wire logic i_lvd_event,
  input wire logic i_adc_eoc,
  input wire logic o_sys_reset,
  input wire logic o_cpu_run,
  input wire logic o_high_osc_en,
  input wire logic o_low_osc_en,
  input wire logic o_periph_en,
  input wire logic [NUM_TIMERS-1:0] o_timer_run,
  input wire logic o_wdt_clear
);
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  a_bus_answer_next: assert property ($rose(i_read || i_write)
    |=> !o_waitrequest) else $error("bus request not answered");
  a_bus_wait_one: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low too long");
  a_run_low_osc: assert property (
    o_cpu_run |-> o_low_osc_en && !o_sys_reset)
    else $error("cpu runs without low oscillator");
  a_halt_all_off: assert property (
    !o_low_osc_en |-> !o_high_osc_en && !o_periph_en && !o_cpu_run
    && o_timer_run == '0) else $error("halt leaves something running");
  a_halt_entry_clear: assert property (
    $fell(o_low_osc_en) |-> $past(o_wdt_clear))
    else $error("halt entered without watchdog clear");
  a_halt_wake_wait: assert property (
    $rose(o_low_osc_en) && !o_sys_reset |-> !o_cpu_run [*8])
    else $error("halt wake resumed too soon");
  a_halt_ignores_sources: assert property (
    !o_low_osc_en && (i_lvd_event || i_adc_eoc) && !i_wdt_timeout
    && !i_port_change && !i_ext_int |=> !o_cpu_run)
    else $error("halt woken by a standby-only source");
  a_standby_wake_fast: assert property (
    o_periph_en && !o_cpu_run && i_adc_eoc |-> ##[1:3] o_cpu_run)
    else $error("standby wake delayed");
  a_wdt_run_reset: assert property (
    o_cpu_run && i_wdt_timeout |-> ##[1:3] o_sys_reset)
    else $error("watchdog in run gave no reset");
  a_pin_reset_seen: assert property (
    $fell(i_reset_pin_n) |-> ##[1:6] o_sys_reset)
    else $error("reset pin ignored");
  a_timers_gated: assert property (
    o_timer_run != '0 |-> o_periph_en)
    else $error("timer runs outside run or standby");
endmodule : lpmrs_checker

bind lpmrs_top lpmrs_checker i_lpmrs_checker (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_read(i_read),
  .i_write(i_write), .o_waitrequest(o_waitrequest),
  .i_reset_pin_n(i_reset_pin_n), .i_wdt_timeout(i_wdt_timeout),
  .i_port_change(i_port_change), .i_ext_int(i_ext_int),
  .i_lvd_event(i_lvd_event), .i_adc_eoc(i_adc_eoc),
  .o_sys_reset(o_sys_reset), .o_cpu_run(o_cpu_run),
  .o_high_osc_en(o_high_osc_en), .o_low_osc_en(o_low_osc_en),
  .o_periph_en(o_periph_en), .o_timer_run(o_timer_run),
  .o_wdt_clear(o_wdt_clear)
);

// [sim/lpmrs_cpu_model.sv]
// model of the cpu core and wake-up sources beside the sequencer
`timescale 1ns/100ps

module lpmrs_cpu_model
(
  input wire logic i_clk_sys,
  output logic [7:0] o_events,
  output logic o_por_detect,
  output logic o_reset_pin_n
);
  // ********************
  // event sources
  // ********************
  // bits: wdt, port, ext, lvd, cmp, adc, sleep, clear-watchdog
  initial
  begin
    o_events = 8'h00;
    o_por_detect = 1'b1;
    o_reset_pin_n = 1'b1;
  end

  task automatic pulse(input int k);
    @(posedge i_clk_sys);
    o_events[k] <= 1'b1;
    @(posedge i_clk_sys);
    o_events <= 8'h00;
  endtask : pulse

  task automatic pin_reset(input int len);
    @(posedge i_clk_sys);
    o_reset_pin_n <= 1'b0;
    repeat (len) @(posedge i_clk_sys);
    o_reset_pin_n <= 1'b1;
  endtask : pin_reset

  task automatic por_release();
    @(posedge i_clk_sys);
    o_por_detect <= 1'b0;
  endtask : por_release
endmodule : lpmrs_cpu_model

// [sim/lpmrs_top_bench.sv]
// self-checking bench of the low-power mode and reset sequencer
`timescale 1ns/100ps

module lpmrs_top_bench
  import lpmrs_pkg::*;
;
  localparam int PWR1 = 50;
  logic i_clk_sys, i_rstn, i_read, i_write, por, pin_n;
  logic [ADDR_W-1:0] i_address;
  logic [31:0] i_writedata, o_readdata, q;
  logic [7:0] ev;
  logic [3:0] be;
  logic low_voltage_reset;
  logic o_waitrequest, o_sys_reset, o_cpu_run, o_high_osc_en;
  logic o_low_osc_en, o_sys_clk_high, o_periph_en, o_wdt_clear;
  logic o_int_vector;
  logic [NUM_TIMERS-1:0] o_timer_run;
  int err_count, checks_done, n, k, j;

  lpmrs_cpu_model i_lpmrs_cpu_model (.i_clk_sys(i_clk_sys),
    .o_events(ev), .o_por_detect(por), .o_reset_pin_n(pin_n));

  lpmrs_top #(.P_PWRUP_T1_CYC(PWR1), .P_PWRUP_T2_CYC(PWR1),
    .P_PWRUP_T3_CYC(PWR1), .P_PWRUP_T4_CYC(PWR1)) i_lpmrs_top (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(be), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_por_detect(por),
    .i_low_voltage_reset(low_voltage_reset), .i_reset_pin_n(pin_n),
    .i_sleep_instr(ev[6]), .i_watchdog_clear_instr(ev[7]),
    .i_wdt_timeout(ev[0]), .i_port_change(ev[1]), .i_ext_int(ev[2]),
    .i_lvd_event(ev[3]), .i_cmp_change(ev[4]), .i_adc_eoc(ev[5]),
    .o_sys_reset(o_sys_reset), .o_cpu_run(o_cpu_run),
    .o_high_osc_en(o_high_osc_en), .o_low_osc_en(o_low_osc_en),
    .o_sys_clk_high(o_sys_clk_high), .o_periph_en(o_periph_en),
    .o_timer_run(o_timer_run), .o_wdt_clear(o_wdt_clear),
    .o_int_vector(o_int_vector));

  // ********************
  // helpers
  // ********************
  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk_sys);
    i_address <= a;
    i_write <= wr;
    i_read <= ~wr;
    i_writedata <= d;
    do
      @(posedge i_clk_sys);
    while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  function automatic logic pick(input int s);
    if (s == 0)
      return o_cpu_run === 1'b1;
    if (s == 1)
      return o_int_vector === 1'b1;
    return o_wdt_clear === 1'b1;
  endfunction : pick

  task automatic wt(input int s, input int lim);
    n = 0;
    while (!pick(s) && n < lim)
    begin
      @(posedge i_clk_sys);
      n++;
    end
  endtask : wt

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial
  begin
    #(30000 * 100);
    err_count++;
    complete_run();
  end

  // ********************
  // tests
  // ********************
  initial
  begin
    i_rstn = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = '0;
    i_writedata = '0;
    be = 4'hf;
    low_voltage_reset = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (4) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    i_lpmrs_cpu_model.por_release();
    wt(0, 2000);
    chk(n > PWRUP_T0_CYC && n < PWRUP_T0_CYC + 12, 1);
    rd(ADDR_OSC_CTRL, 32'h1);
    rd(ADDR_STATUS, 32'h18);
    rd(ADDR_CONFIG, 32'h0);
    rd(8'h40, 32'h0);
    i_lpmrs_cpu_model.pulse(7);
    wt(2, 4);
    chk(n < 4, 1);
    rd(ADDR_STATUS, 32'h18);
    i_lpmrs_cpu_model.pulse(0);
    repeat (4) @(posedge i_clk_sys);
    chk(o_sys_reset, 1);
    wt(0, 2000);
    rd(ADDR_STATUS, 32'h08);
    bus(1'b1, ADDR_CONFIG, 32'h1);
    i_lpmrs_cpu_model.pin_reset(5);
    wt(0, 200);
    chk(n >= PWR1 + 16 && n <= PWR1 + 26, 1);
    rd(ADDR_STATUS, 32'h08);
    rd(ADDR_CONFIG, 32'h1);
    $display("test reset sources done");
    bus(1'b1, ADDR_TIMER_EN, 32'h1);
    bus(1'b1, ADDR_RELOAD_BASE, 32'h3ff);
    bus(1'b1, ADDR_OSC_CTRL, 32'h0);
    bus(1'b1, ADDR_OSC_CTRL, 32'h8);
    repeat (3) @(posedge i_clk_sys);
    chk({o_cpu_run, o_low_osc_en, o_high_osc_en, o_periph_en,
         o_timer_run}, 8'h71);
    wt(0, 1100);
    chk(n < 1100, 1);
    rd(ADDR_OSC_CTRL, 32'h0);
    chk(o_sys_clk_high, 0);
    bus(1'b1, ADDR_TIMER_EN, 32'h0);
    for (k = 0; k < 6; k++)
    begin
      bus(1'b1, ADDR_OSC_CTRL, 32'ha);
      repeat (3) @(posedge i_clk_sys);
      chk(o_high_osc_en, 0);
      i_lpmrs_cpu_model.pulse(k);
      wt(0, 6);
      chk(n < 4, 1);
    end
    rd(ADDR_STATUS, 32'h08);
    $display("test standby done");
    bus(1'b1, ADDR_CONFIG, 32'h10);
    for (k = 0; k < 3; k++)
    begin
      bus(1'b1, ADDR_OSC_CTRL, 32'h6);
      repeat (3) @(posedge i_clk_sys);
      chk({o_low_osc_en, o_high_osc_en, o_periph_en, o_timer_run}, 0);
      rd(ADDR_STATUS, 32'h10);
      for (j = 3; j < 6; j++)
        i_lpmrs_cpu_model.pulse(j);
      repeat (2) @(posedge i_clk_sys);
      chk(o_low_osc_en, 0);
      i_lpmrs_cpu_model.pulse(k);
      wt(1, 40);
      chk(n >= 15 && n <= 22, 1);
      wt(0, 10);
      rd(ADDR_STATUS, (k == 0) ? 32'h0 : 32'h10);
    end
    bus(1'b1, ADDR_CONFIG, 32'h19);
    bus(1'b1, ADDR_OSC_CTRL, 32'h1);
    i_lpmrs_cpu_model.pulse(6);
    repeat (3) @(posedge i_clk_sys);
    rd(ADDR_STATUS, 32'h10);
    i_lpmrs_cpu_model.pulse(1);
    wt(1, 600);
    chk(n >= 511 && n <= 518, 1);
    wt(0, 10);
    chk(o_sys_clk_high, 1);
    bus(1'b1, ADDR_OSC_CTRL, 32'h5);
    repeat (3) @(posedge i_clk_sys);
    i_lpmrs_cpu_model.pin_reset(5);
    wt(0, 200);
    rd(ADDR_STATUS, 32'h18);
    $display("test halt done");
    be <= 4'h0;
    bus(1'b1, ADDR_OSC_CTRL, 32'h4);
    be <= 4'hf;
    rd(ADDR_STATE, 32'h08);
    rd(ADDR_CONFIG, 32'h09);
    i_lpmrs_cpu_model.pulse(6);
    repeat (3) @(posedge i_clk_sys);
    low_voltage_reset <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    low_voltage_reset <= 1'b0;
    wt(0, 200);
    chk(n >= PWR1 + 16 && n <= PWR1 + 26, 1);
    rd(ADDR_STATUS, 32'h18);
    $display("test low voltage done");
    complete_run();
  end
endmodule : lpmrs_top_bench
